// ---- addr_mux_pkg.sv ----
package addr_mux_pkg;
    // ------------------------------------------------------------
    // Register map, byte addresses
    // ------------------------------------------------------------
    localparam int ADDR_W = 6;
    localparam logic [ADDR_W-1:0] OFS_BUS_CTRL = 6'h00;
    localparam logic [ADDR_W-1:0] OFS_PA_PULLUP = 6'h04;
    localparam logic [ADDR_W-1:0] OFS_PA_FUNC = 6'h08;
    localparam logic [ADDR_W-1:0] OFS_PA_DIR = 6'h0C;
    localparam logic [ADDR_W-1:0] OFS_PA_DATA = 6'h10;
    localparam logic [ADDR_W-1:0] OFS_PA_PIN = 6'h14;
    localparam logic [ADDR_W-1:0] OFS_PE_PULLUP = 6'h18;
    localparam logic [ADDR_W-1:0] OFS_PE_FUNC = 6'h1C;
    localparam logic [ADDR_W-1:0] OFS_PE_DIR = 6'h20;
    localparam logic [ADDR_W-1:0] OFS_PE_DATA = 6'h24;
    localparam logic [ADDR_W-1:0] OFS_PE_PIN = 6'h28;

    // ------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------
    localparam int PORT_W = 16;
    localparam int DRIVE_HOLD_BIT = 0;
    localparam int PA_LSB = 8;
    localparam int PA_N = 6;
    localparam int PE_LSB = 2;
    localparam int PE_N = 2;
    localparam logic [PORT_W-1:0] PA_MASK = 16'h3F00;
    localparam logic [PORT_W-1:0] PE_MASK = 16'h000C;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic DRIVE_HOLD_RST = 1'b0;
    localparam logic [PORT_W-1:0] PULLUP_RST = 16'hFFFF;
    localparam logic [PORT_W-1:0] FUNC_RST = 16'hFFFF;
    localparam logic [PORT_W-1:0] DIR_RST = 16'h0000;
    localparam logic [PORT_W-1:0] DATA_RST = 16'h0000;

    // ------------------------------------------------------------
    // Bus answers
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- pin_sync.sv ----
`timescale 1ns/100ps
module pin_sync #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule

// ---- ext_address_pin_mux.sv ----
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
// Contract
// - Address function drives memory address bits 0..5 on port A pins 8..13.
// - Address function drives memory address bits 6..7 on port E pins 2..3.
// - Idle bus tri-states address and control outputs unless bus_drive_hold set.
// - Each shared port A pin individually input or output in GPIO mode.
// - Each shared port E pin individually input or output in GPIO mode.
// - After reset every shared pin selects address-bus function.
// - Clearing port A pull-up bit (index = GPIO number, from 8) disables pull-up.
// - Clearing port E pull-up bit (index = GPIO number, from 2) disables pull-up.
module ext_address_pin_mux
    import addr_mux_pkg::*;
#(
    parameter int CTRL_W = 4
) (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RST,
    // AXI4-Lite slave
    input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // Memory interface side
    input wire logic [7:0] MEM_ADDR,
    input wire logic [CTRL_W-1:0] MEM_CTRL,
    input wire logic MEM_ACTIVE,
    // Port A shared pins (GPIO 8..13)
    input wire logic [PA_N-1:0] PA_IN,
    output logic [PA_N-1:0] PA_OUT,
    output logic [PA_N-1:0] PA_OE,
    output logic [PA_N-1:0] PA_PULLUP,
    // Port E shared pins (GPIO 2..3)
    input wire logic [PE_N-1:0] PE_IN,
    output logic [PE_N-1:0] PE_OUT,
    output logic [PE_N-1:0] PE_OE,
    output logic [PE_N-1:0] PE_PULLUP,
    // Memory control pins
    output logic [CTRL_W-1:0] CTRL_OUT,
    output logic [CTRL_W-1:0] CTRL_OE
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic drive_hold_q;
    logic [PORT_W-1:0] pa_pullup_q, pa_func_q, pa_dir_q, pa_data_q;
    logic [PORT_W-1:0] pe_pullup_q, pe_func_q, pe_dir_q, pe_data_q;
    logic [PA_N-1:0] pa_sync;
    logic [PE_N-1:0] pe_sync;
    logic [PORT_W-1:0] pa_pin_w, pe_pin_w;

    // Byte-lane merge limited to the implemented bits
    function automatic logic [PORT_W-1:0] merge(input logic [PORT_W-1:0] old,
                                                input logic [31:0] wd,
                                                input logic [3:0] strb,
                                                input logic [PORT_W-1:0] mask);
        logic [PORT_W-1:0] lanes;
        lanes = {{8{strb[1]}}, {8{strb[0]}}} & mask;
        return (old & ~lanes) | (wd[PORT_W-1:0] & lanes);
    endfunction

    // ------------------------------------------------------------
    // Pin input synchronisers
    // ------------------------------------------------------------
    pin_sync #(.W(PA_N + PE_N)) u_sync (
        .clk(CLK_SYS),
        .rst(RST),
        .d({PE_IN, PA_IN}),
        .q({pe_sync, pa_sync})
    );

    assign pa_pin_w = PORT_W'({pa_sync, 8'h00});
    assign pe_pin_w = PORT_W'({pe_sync, 2'h0});

    // ------------------------------------------------------------
    // AXI4-Lite write path
    // ------------------------------------------------------------
    logic aw_held_q, w_held_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic do_write, wr_hit;

    assign do_write = aw_held_q && w_held_q && !S_AXI_BVALID;

    always_comb begin
        case (aw_addr_q)
            OFS_BUS_CTRL, OFS_PA_PULLUP, OFS_PA_FUNC, OFS_PA_DIR, OFS_PA_DATA,
            OFS_PE_PULLUP, OFS_PE_FUNC, OFS_PE_DIR, OFS_PE_DATA: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= '0;
            S_AXI_AWREADY <= 1'b0;
        end else if (S_AXI_AWREADY && S_AXI_AWVALID) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= S_AXI_AWADDR;
            S_AXI_AWREADY <= 1'b0;
        end else if (do_write) begin
            aw_held_q <= 1'b0;
        end else begin
            S_AXI_AWREADY <= !aw_held_q;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            w_held_q <= 1'b0;
            w_data_q <= '0;
            w_strb_q <= '0;
            S_AXI_WREADY <= 1'b0;
        end else if (S_AXI_WREADY && S_AXI_WVALID) begin
            w_held_q <= 1'b1;
            w_data_q <= S_AXI_WDATA;
            w_strb_q <= S_AXI_WSTRB;
            S_AXI_WREADY <= 1'b0;
        end else if (do_write) begin
            w_held_q <= 1'b0;
        end else begin
            S_AXI_WREADY <= !w_held_q;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= RESP_OKAY;
        end else if (do_write) begin
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            drive_hold_q <= DRIVE_HOLD_RST;
        end else if (do_write && aw_addr_q == OFS_BUS_CTRL && w_strb_q[0]) begin
            drive_hold_q <= w_data_q[DRIVE_HOLD_BIT];
        end
    end

    // Only the shared bits exist; the rest of each port lives elsewhere
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            pa_pullup_q <= PULLUP_RST & PA_MASK;
            pa_func_q <= FUNC_RST & PA_MASK;
            pa_dir_q <= DIR_RST;
            pa_data_q <= DATA_RST;
        end else if (do_write) begin
            case (aw_addr_q)
                OFS_PA_PULLUP: pa_pullup_q <= merge(pa_pullup_q, w_data_q, w_strb_q, PA_MASK);
                OFS_PA_FUNC: pa_func_q <= merge(pa_func_q, w_data_q, w_strb_q, PA_MASK);
                OFS_PA_DIR: pa_dir_q <= merge(pa_dir_q, w_data_q, w_strb_q, PA_MASK);
                OFS_PA_DATA: pa_data_q <= merge(pa_data_q, w_data_q, w_strb_q, PA_MASK);
                default: ;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            pe_pullup_q <= PULLUP_RST & PE_MASK;
            pe_func_q <= FUNC_RST & PE_MASK;
            pe_dir_q <= DIR_RST;
            pe_data_q <= DATA_RST;
        end else if (do_write) begin
            case (aw_addr_q)
                OFS_PE_PULLUP: pe_pullup_q <= merge(pe_pullup_q, w_data_q, w_strb_q, PE_MASK);
                OFS_PE_FUNC: pe_func_q <= merge(pe_func_q, w_data_q, w_strb_q, PE_MASK);
                OFS_PE_DIR: pe_dir_q <= merge(pe_dir_q, w_data_q, w_strb_q, PE_MASK);
                OFS_PE_DATA: pe_data_q <= merge(pe_data_q, w_data_q, w_strb_q, PE_MASK);
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read path
    // ------------------------------------------------------------
    logic [PORT_W-1:0] rd_val;
    logic rd_hit;

    always_comb begin
        rd_hit = 1'b1;
        case (S_AXI_ARADDR)
            OFS_BUS_CTRL: rd_val = PORT_W'(drive_hold_q);
            OFS_PA_PULLUP: rd_val = pa_pullup_q;
            OFS_PA_FUNC: rd_val = pa_func_q;
            OFS_PA_DIR: rd_val = pa_dir_q;
            OFS_PA_DATA: rd_val = pa_data_q;
            OFS_PA_PIN: rd_val = pa_pin_w;
            OFS_PE_PULLUP: rd_val = pe_pullup_q;
            OFS_PE_FUNC: rd_val = pe_func_q;
            OFS_PE_DIR: rd_val = pe_dir_q;
            OFS_PE_DATA: rd_val = pe_data_q;
            OFS_PE_PIN: rd_val = pe_pin_w;
            default: begin
                rd_val = '0;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= '0;
            S_AXI_RRESP <= RESP_OKAY;
        end else if (S_AXI_ARREADY && S_AXI_ARVALID) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA <= {16'h0000, rd_val};
            S_AXI_RRESP <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (S_AXI_RVALID) begin
            S_AXI_RVALID <= !S_AXI_RREADY;
        end else begin
            S_AXI_ARREADY <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Pin multiplexing
    // ------------------------------------------------------------
    // Without drive hold the bus floats between accesses; the pull-ups
    // keep idle levels defined, but external decoders may still glitch.
    logic bus_drive;
    assign bus_drive = MEM_ACTIVE || drive_hold_q;

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            PA_OUT <= '0;
            PA_OE <= '0;
            PA_PULLUP <= '1;
        end else begin
            for (int i = 0; i < PA_N; i++) begin
                if (pa_func_q[PA_LSB+i]) begin
                    PA_OUT[i] <= MEM_ADDR[i];
                    PA_OE[i] <= bus_drive;
                end else begin
                    PA_OUT[i] <= pa_data_q[PA_LSB+i];
                    PA_OE[i] <= pa_dir_q[PA_LSB+i];
                end
                PA_PULLUP[i] <= pa_pullup_q[PA_LSB+i];
            end
        end
    end

    // ------------------------------------------------------------
    // Port E pins
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            PE_OUT <= '0;
            PE_OE <= '0;
            PE_PULLUP <= '1;
        end else begin
            for (int j = 0; j < PE_N; j++) begin
                if (pe_func_q[PE_LSB+j]) begin
                    PE_OUT[j] <= MEM_ADDR[PA_N+j];
                    PE_OE[j] <= bus_drive;
                end else begin
                    PE_OUT[j] <= pe_data_q[PE_LSB+j];
                    PE_OE[j] <= pe_dir_q[PE_LSB+j];
                end
                PE_PULLUP[j] <= pe_pullup_q[PE_LSB+j];
            end
        end
    end

    // ------------------------------------------------------------
    // Memory control pins
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            CTRL_OUT <= '0;
            CTRL_OE <= '0;
        end else begin
            CTRL_OUT <= MEM_CTRL;
            CTRL_OE <= {CTRL_W{bus_drive}};
        end
    end
endmodule

// ---- ext_address_pin_mux_assertions.sv ----
`timescale 1ns/100ps
module pin_mux_checker
    import addr_mux_pkg::*;
#(
    parameter int CTRL_W = 4
) (
    // Clock, reset and bus
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_RVALID,
    // Memory side and pins
    input wire logic [7:0] MEM_ADDR,
    input wire logic [CTRL_W-1:0] MEM_CTRL,
    input wire logic MEM_ACTIVE,
    input wire logic [PA_N-1:0] PA_OUT,
    input wire logic [PA_N-1:0] PA_OE,
    input wire logic [PA_N-1:0] PA_PULLUP,
    input wire logic [PE_N-1:0] PE_OUT,
    input wire logic [PE_N-1:0] PE_OE,
    input wire logic [PE_N-1:0] PE_PULLUP,
    input wire logic [CTRL_W-1:0] CTRL_OUT,
    input wire logic [CTRL_W-1:0] CTRL_OE
);
    // Registers unseen here, so default checks stop at first write
    logic cfg_q;
    always_ff @(posedge CLK_SYS) begin
        if (RST) cfg_q <= 1'b0;
        else if (S_AXI_AWVALID && S_AXI_AWREADY) cfg_q <= 1'b1;
    end
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    sequence s_fresh;
        !RST ##1 !cfg_q;
    endsequence
    a_pa_addr_out: assert property (s_fresh |=> PA_OUT == $past(MEM_ADDR[5:0]))
        else $error("port A address wrong");
    a_pe_addr_out: assert property (s_fresh |=> PE_OUT == $past(MEM_ADDR[7:6]))
        else $error("port E address wrong");
    a_idle_float: assert property (s_fresh ##0 !MEM_ACTIVE |=> !PA_OE && !PE_OE && !CTRL_OE)
        else $error("idle bus still driven");
    a_active_drive: assert property (s_fresh ##0 MEM_ACTIVE |=> &PA_OE && &PE_OE && &CTRL_OE)
        else $error("active bus not driven");
    a_ctrl_follow: assert property (!RST |=> CTRL_OUT == $past(MEM_CTRL))
        else $error("control outputs wrong");
    a_pull_default: assert property (!cfg_q |-> &PA_PULLUP && &PE_PULLUP)
        else $error("pull-up off by default");
    a_reset_safe: assert property (disable iff (1'b0) RST |=> !PA_OE && !PE_OE && &PA_PULLUP && &PE_PULLUP)
        else $error("pins unsafe in reset");
    a_bus_quiet: assert property (disable iff (1'b0) RST |=> !S_AXI_BVALID && !S_AXI_RVALID)
        else $error("bus answer in reset");
endmodule
bind ext_address_pin_mux pin_mux_checker #(.CTRL_W(CTRL_W)) chk_u (.CLK_SYS(CLK_SYS), .RST(RST),
    .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_BVALID(S_AXI_BVALID),
    .S_AXI_RVALID(S_AXI_RVALID), .MEM_ADDR(MEM_ADDR), .MEM_CTRL(MEM_CTRL), .MEM_ACTIVE(MEM_ACTIVE),
    .PA_OUT(PA_OUT), .PA_OE(PA_OE), .PA_PULLUP(PA_PULLUP), .PE_OUT(PE_OUT), .PE_OE(PE_OE),
    .PE_PULLUP(PE_PULLUP), .CTRL_OUT(CTRL_OUT), .CTRL_OE(CTRL_OE));

// ---- ext_mem_model.sv ----
`timescale 1ns/100ps
module ext_mem_model (
    // Clock and stimulus
    input wire logic clk,
    input wire logic ext_low,
    // Device pins, port E above port A
    input wire logic [7:0] out,
    input wire logic [7:0] oe,
    input wire logic [7:0] pu,
    output logic [7:0] pin,
    output logic [7:0] seen
);
    logic [7:0] last_q;
    // Undriven pins read 0 under ext_low, 1 with pull-up, else flip so a stale value never reads as a match
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pin[i] = oe[i] ? out[i] : (ext_low ? 1'b0 : (pu[i] ? 1'b1 : ~last_q[i]));
        end
    end
    always_ff @(posedge clk) begin
        last_q <= pin;
        if (&oe) seen <= pin;
    end
endmodule

// ---- test_ext_address_pin_mux.sv ----
`timescale 1ns/100ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin miscompares++; \
    $display("[ERR] %0t got %h want %h", $time, (a), (e)); end end
module test_ext_address_pin_mux;
    import addr_mux_pkg::*;
    logic clk = 0, rst = 1, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
    logic mem_active = 0, ext_low = 0;
    logic [5:0] awaddr = 0, araddr = 0, pa_in, pa_out, pa_oe, pa_pu;
    logic [31:0] wdata = 0, rdata;
    logic [7:0] mem_addr = 0, seen;
    logic [3:0] mem_ctrl = 4'h9, ctrl_out, ctrl_oe;
    logic awready, wready, arready, bvalid, rvalid;
    logic [1:0] bresp, rresp, pe_in, pe_out, pe_oe, pe_pu;
    int miscompares = 0, checks_done = 0;
    ext_address_pin_mux #(.CTRL_W(4)) dut_u (.CLK_SYS(clk), .RST(rst), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
        .S_AXI_WVALID(wv), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready), .MEM_ADDR(mem_addr), .MEM_CTRL(mem_ctrl), .MEM_ACTIVE(mem_active),
        .PA_IN(pa_in), .PA_OUT(pa_out), .PA_OE(pa_oe), .PA_PULLUP(pa_pu), .PE_IN(pe_in),
        .PE_OUT(pe_out), .PE_OE(pe_oe), .PE_PULLUP(pe_pu), .CTRL_OUT(ctrl_out), .CTRL_OE(ctrl_oe));
    ext_mem_model mem_u (.clk(clk), .ext_low(ext_low), .out({pe_out, pa_out}),
        .oe({pe_oe, pa_oe}), .pu({pe_pu, pa_pu}), .pin({pe_in, pa_in}), .seen(seen));
    initial begin
        forever #50 clk = ~clk;
    end
    // ------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------
    task automatic finish_test;
        if (miscompares == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic limit(input int n);
        if (n >= 50) begin
            miscompares++;
            $display("[ERR] %0t bus answer timed out", $time);
            finish_test();
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        logic pa, pw;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        pa = 1'b1;
        pw = 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (pa && awready === 1'b1) begin
                awv <= 1'b0;
                pa = 1'b0;
            end
            if (pw && wready === 1'b1) begin
                wv <= 1'b0;
                pw = 1'b0;
            end
        end while (bvalid !== 1'b1 && n < 50);
        limit(n);
        bready <= 1'b0;
        `CHK(bresp, er)
    endtask
    task automatic rd(input logic [5:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        @(posedge clk);
        araddr <= a;
        arv <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (arready === 1'b1) arv <= 1'b0;
        end while (rvalid !== 1'b1 && n < 50);
        limit(n);
        rready <= 1'b0;
        `CHK(rdata, ed)
        `CHK(rresp, er)
    endtask
    // Pins lag one clock, pin reads two more
    task automatic settle;
        repeat (4) @(posedge clk);
        @(negedge clk);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        @(posedge clk);
        @(negedge clk);
        `CHK({pe_oe, pa_oe}, 8'h00)
        `CHK({pe_pu, pa_pu}, 8'hFF)
        @(posedge clk);
        rst <= 1'b0;
        rd(OFS_PA_FUNC, {16'h0000, PA_MASK}, RESP_OKAY);
        rd(OFS_PE_FUNC, {16'h0000, PE_MASK}, RESP_OKAY);
        rd(OFS_BUS_CTRL, 32'h0000_0000, RESP_OKAY);
        @(posedge clk);
        mem_addr <= 8'hA5;
        mem_active <= 1'b1;
        settle();
        `CHK({pe_out, pa_out}, 8'hA5)
        `CHK({pe_oe, pa_oe, ctrl_oe}, 12'hFFF)
        `CHK(seen, 8'hA5)
        @(posedge clk);
        mem_active <= 1'b0;
        settle();
        `CHK({pe_oe, pa_oe, ctrl_oe}, 12'h000)
        wr(OFS_BUS_CTRL, 32'h0000_0001, RESP_OKAY);
        mem_ctrl <= 4'h6;
        settle();
        `CHK({pe_oe, pa_oe, ctrl_oe}, 12'hFFF)
        `CHK(ctrl_out, 4'h6)
        @(posedge clk);
        mem_addr <= 8'h5A;
        wr(OFS_PA_FUNC, 32'h0000_0000, RESP_OKAY);
        wr(OFS_PA_DIR, 32'h0000_1500, RESP_OKAY);
        wr(OFS_PA_DATA, 32'h0000_3F00, RESP_OKAY);
        wr(OFS_PE_FUNC, 32'h0000_0000, RESP_OKAY);
        wr(OFS_PE_DIR, 32'h0000_0008, RESP_OKAY);
        wr(OFS_PE_DATA, 32'h0000_000C, RESP_OKAY);
        ext_low <= 1'b1;
        settle();
        `CHK({pe_oe, pa_oe}, 8'h95)
        `CHK({pe_out, pa_out}, 8'hFF)
        rd(OFS_PA_PIN, 32'h0000_1500, RESP_OKAY);
        rd(OFS_PE_PIN, 32'h0000_0008, RESP_OKAY);
        for (int i = 0; i < PA_N; i++) begin
            wr(OFS_PA_DIR, 32'(1) << (PA_LSB + i), RESP_OKAY);
            settle();
            `CHK(pa_oe, 6'(1 << i))
        end
        wr(OFS_PA_PULLUP, 32'h0000_3E00, RESP_OKAY);
        wr(OFS_PE_PULLUP, 32'h0000_0008, RESP_OKAY);
        settle();
        `CHK({pe_pu, pa_pu}, 8'hBE)
        rd(OFS_PA_PULLUP, 32'h0000_3E00, RESP_OKAY);
        rd(6'h2C, 32'h0000_0000, RESP_SLVERR);
        wr(6'h2C, 32'h0000_0001, RESP_SLVERR);
        wr(OFS_PA_PIN, 32'h0000_FFFF, RESP_SLVERR);
        @(posedge clk);
        rst <= 1'b1;
        ext_low <= 1'b0;
        mem_active <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(OFS_PE_FUNC, {16'h0000, PE_MASK}, RESP_OKAY);
        settle();
        `CHK({pe_out, pa_out}, 8'h5A)
        `CHK(seen, 8'h5A)
        finish_test();
    end
endmodule
